// [inc/csrb_defines.svh]
`ifndef CSRB_DEFINES_SVH
`define CSRB_DEFINES_SVH

// file addresses of the core registers
`define CSRB_ADDR_INDIRECT   5'h00
`define CSRB_ADDR_TIMER      5'h01
`define CSRB_ADDR_PCL        5'h02
`define CSRB_ADDR_FLAGS      5'h03
`define CSRB_ADDR_POINTER    5'h04
`define CSRB_ADDR_PORT_A     5'h05
`define CSRB_ADDR_PORT_B     5'h06
// general purpose window
`define CSRB_GPR_BASE        5'h07
`define CSRB_GPR_COUNT       25

// configuration-load selectors carried with the load strobe
`define CSRB_CFG_DIR_A       3'h5
`define CSRB_CFG_DIR_B       3'h6
`define CSRB_CFG_ADDED       3'h7

// flag register bit positions
`define CSRB_BIT_CARRY       0
`define CSRB_BIT_NIBBLE      1
`define CSRB_BIT_ZERO        2
`define CSRB_BIT_SLEEP       3
`define CSRB_BIT_WATCHDOG    4
`define CSRB_BIT_WIN_LSB     5
`define CSRB_BIT_WIN_MSB     6
`define CSRB_BIT_PCWAKE      7

// reset values
`define CSRB_RST_PCL         8'hff
`define CSRB_RST_DIR_A       4'hf
`define CSRB_RST_DIR_B       8'hff
`define CSRB_RST_CFG6        6'h3f
`define CSRB_RST_PTR_TOP     3'h7
`define CSRB_RST_FLAGS_POR   8'h98
`define CSRB_ZERO8           8'h00

`endif

// [inc/csrb_pkg.sv]
package csrb_pkg;

   // cause of the reset being applied, one-hot
   typedef enum logic [4:0] {
      CSRB_CAUSE_POR  = 5'b0_0001,
      CSRB_CAUSE_EXT  = 5'b0_0010,
      CSRB_CAUSE_WDT  = 5'b0_0100,
      CSRB_CAUSE_BOR  = 5'b0_1000,
      CSRB_CAUSE_WAKE = 5'b1_0000
   } csrb_cause_t;

endpackage

// [core/csrb_gpr_file.sv]
`timescale 1ns/1ps
`include "csrb_defines.svh"

// general purpose data memory, combinational read, clocked write
module csrb_gpr_file (
   input  wire logic       clock,
   input  wire logic       ce,
   input  wire logic       wr_en,
   input  wire logic [4:0] addr,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data,
   output logic            hit
);
   logic [7:0] mem [`CSRB_GPR_COUNT];   // storage cells
   logic [4:0] index;                    // offset into the window

   // window decode
   assign hit   = (addr >= `CSRB_GPR_BASE);
   assign index = addr - `CSRB_GPR_BASE;
   assign rd_data = hit ? mem[index] : `CSRB_ZERO8;

   // write port, contents kept across every reset
   always_ff @(posedge clock) begin
      if (ce && wr_en && hit) begin
         mem[index] <= wr_data;
      end
   end
endmodule

// [core/csrb_special_regs.sv]
`timescale 1ns/1ps
`include "csrb_defines.svh"

module csrb_special_regs
   import csrb_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire csrb_cause_t reset_cause,
   input  wire logic [4:0]  file_addr,
   input  wire logic        rd_en,
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_data,
   input  wire logic [2:0]  flag_upd,
   input  wire logic        alu_carry,
   input  wire logic        alu_nibble,
   input  wire logic        alu_zero,
   input  wire logic        sleep_op,
   input  wire logic        wdt_clear_op,
   input  wire logic        option_load,
   input  wire logic        cfg_load,
   input  wire logic [2:0]  cfg_sel,
   input  wire logic [7:0]  acc_data,
   input  wire logic        timer_inc,
   input  wire logic        pc_low_upd,
   input  wire logic [7:0]  pc_low_in,
   input  wire logic [3:0]  pin_a_in,
   input  wire logic [7:0]  pin_b_in,
   output logic      [7:0]  rd_data,
   output logic      [7:0]  flags_out,
   output logic      [7:0]  timer_count_out,
   output logic      [7:0]  pc_low_out,
   output logic      [3:0]  pin_a_latch,
   output logic      [7:0]  pin_b_latch,
   output logic      [3:0]  dir_a,
   output logic      [7:0]  dir_b,
   output logic      [5:0]  timer_prescale_cfg,
   output logic      [5:0]  added_feature_cfg
);

   // state registers
   logic [7:0] flags_reg, flags_next;   // arithmetic / reset flags and next value
   logic [4:0] pointer_reg;      // implemented pointer bits
   logic [7:0] timer_reg;        // timer count
   logic [7:0] pcl_reg;          // low program counter byte
   logic [3:0] lat_a_reg;        // port a output latch
   logic [7:0] lat_b_reg;        // port b output latch
   logic [3:0] dir_a_reg;        // port a direction
   logic [7:0] dir_b_reg;        // port b direction
   logic [5:0] prescale_reg;     // timer prescale config
   logic [5:0] added_reg;        // added-feature config
   logic [7:0] rd_data_reg;      // registered read answer

   // pin input synchronisers, three stages
   logic [11:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;   // stages one to three
   logic [11:0] pin_val_reg;     // accepted pin level

   // decode wires
   logic [4:0] eff_addr;         // address after indirection
   logic       is_indirect, wr_now;   // pointer access, destination-write strobe
   logic       wr_timer, wr_pcl, wr_flags;        // per-register write strobes
   logic       wr_pointer, wr_port_a, wr_port_b;
   logic       gpr_hit;
   logic [7:0] gpr_rdata;
   logic [7:0] rd_mux;
   logic [7:0] pointer_view;
   logic       ld_dir_a, ld_dir_b, ld_added, ld_prescale;   // config load strobes
   logic [2:0] alu_flags;        // computed {zero, nibble, carry}

   // indirection: address zero points through the pointer
   assign is_indirect = (file_addr == `CSRB_ADDR_INDIRECT);
   assign eff_addr    = is_indirect ? pointer_reg : file_addr;
   assign wr_now      = ce && wr_en;

   // write decode on the effective address
   assign wr_timer   = wr_now && (eff_addr == `CSRB_ADDR_TIMER);
   assign wr_pcl     = wr_now && (eff_addr == `CSRB_ADDR_PCL);
   assign wr_flags   = wr_now && (eff_addr == `CSRB_ADDR_FLAGS);
   assign wr_pointer = wr_now && (eff_addr == `CSRB_ADDR_POINTER);
   assign wr_port_a  = wr_now && (eff_addr == `CSRB_ADDR_PORT_A);
   assign wr_port_b  = wr_now && (eff_addr == `CSRB_ADDR_PORT_B);

   // configuration loads, only through the dedicated instructions
   assign ld_prescale = ce && option_load;
   assign ld_dir_a    = ce && cfg_load && (cfg_sel == `CSRB_CFG_DIR_A);
   assign ld_dir_b    = ce && cfg_load && (cfg_sel == `CSRB_CFG_DIR_B);
   assign ld_added    = ce && cfg_load && (cfg_sel == `CSRB_CFG_ADDED);

   // pointer reads back with its unimplemented top bits as ones
   assign pointer_view = {`CSRB_RST_PTR_TOP, pointer_reg};

   // general purpose storage, direct or indirect
   csrb_gpr_file u_gpr (
      .clock   (clock),
      .ce      (ce),
      .wr_en   (wr_en),
      .addr    (eff_addr),
      .wr_data (wr_data),
      .rd_data (gpr_rdata),
      .hit     (gpr_hit)
   );

   // read selection; config registers have no read path
   assign rd_mux =
      (eff_addr == `CSRB_ADDR_INDIRECT) ? `CSRB_ZERO8 :
      (eff_addr == `CSRB_ADDR_TIMER)    ? timer_reg :
      (eff_addr == `CSRB_ADDR_PCL)      ? pcl_reg :
      (eff_addr == `CSRB_ADDR_FLAGS)    ? flags_reg :
      (eff_addr == `CSRB_ADDR_POINTER)  ? pointer_view :
      (eff_addr == `CSRB_ADDR_PORT_A)   ? {4'h0, pin_val_reg[3:0]} :
      (eff_addr == `CSRB_ADDR_PORT_B)   ? pin_val_reg[11:4] :
      gpr_hit                           ? gpr_rdata : `CSRB_ZERO8;

   // computed flags in register bit order
   assign alu_flags = {alu_zero, alu_nibble, alu_carry};

   // next flag value: software part, then hardware overrides
   always_comb begin
      flags_next = flags_reg;
      if (wr_flags) begin
         // window and wake bits take the written value
         flags_next[`CSRB_BIT_PCWAKE:`CSRB_BIT_WIN_LSB] =
            wr_data[`CSRB_BIT_PCWAKE:`CSRB_BIT_WIN_LSB];
         // all three arithmetic bits locked once any is computed
         if (flag_upd == 3'h0) begin
            flags_next[`CSRB_BIT_ZERO:`CSRB_BIT_CARRY] = wr_data[`CSRB_BIT_ZERO:`CSRB_BIT_CARRY];
         end
      end
      // instruction results always win over the written value
      if (ce) begin
         for (int i = 0; i < 3; i++) begin
            if (flag_upd[i]) begin
               flags_next[i] = alu_flags[i];
            end
         end
      end
      // watchdog and sleep flags move only by hardware
      if (ce && sleep_op) begin
         flags_next[`CSRB_BIT_SLEEP]    = 1'b0;
         flags_next[`CSRB_BIT_WATCHDOG] = 1'b1;
      end else if (ce && wdt_clear_op) begin
         flags_next[`CSRB_BIT_SLEEP]    = 1'b1;
         flags_next[`CSRB_BIT_WATCHDOG] = 1'b1;
      end
   end

   // flag register with per-cause reset values
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         unique case (reset_cause)
            CSRB_CAUSE_POR:  flags_reg <= `CSRB_RST_FLAGS_POR;
            CSRB_CAUSE_EXT:  flags_reg <= {3'b100, flags_reg[4:0]};
            CSRB_CAUSE_WDT:  flags_reg <= {3'b100, 1'b0, flags_reg[3:0]};
            CSRB_CAUSE_BOR:  flags_reg <= {flags_reg[7], 2'b00, flags_reg[4:0]};
            CSRB_CAUSE_WAKE: flags_reg <= {3'b000, flags_reg[4:0]};
            default:         flags_reg <= `CSRB_RST_FLAGS_POR;   // illegal cause code
         endcase
      end else if (ce) begin
         flags_reg <= flags_next;
      end
   end

   // low program counter byte, reset to ones
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pcl_reg <= `CSRB_RST_PCL;
      end else if (wr_pcl) begin
         pcl_reg <= wr_data;
      end else if (ce && pc_low_upd) begin
         pcl_reg <= pc_low_in;
      end
   end

   // timer: software load beats the count pulse
   always_ff @(posedge clock) begin
      if (wr_timer) begin
         timer_reg <= wr_data;
      end else if (ce && timer_inc) begin
         timer_reg <= timer_reg + 8'h01;
      end
   end

   // pointer and port latches, contents kept across resets
   always_ff @(posedge clock) begin
      if (wr_pointer) begin
         pointer_reg <= wr_data[4:0];
      end
      if (wr_port_a) begin
         lat_a_reg <= wr_data[3:0];
      end
      if (wr_port_b) begin
         lat_b_reg <= wr_data;
      end
   end

   // direction registers, loaded only from the accumulator
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dir_a_reg <= `CSRB_RST_DIR_A;
         dir_b_reg <= `CSRB_RST_DIR_B;
      end else begin
         if (ld_dir_a) begin
            dir_a_reg <= acc_data[3:0];
         end
         if (ld_dir_b) begin
            dir_b_reg <= acc_data;
         end
      end
   end

   // timer prescale config: any reset to ones, load from accumulator
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prescale_reg <= `CSRB_RST_CFG6;
      end else if (ld_prescale) begin
         prescale_reg <= acc_data[5:0];
      end
   end

   // added-feature config: only power-on resets it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         if (reset_cause == CSRB_CAUSE_POR) begin
            added_reg <= `CSRB_RST_CFG6;
         end
      end else if (ld_added) begin
         added_reg <= acc_data[5:0];
      end
   end

   // pin synchroniser; accept a level once stages two and three agree
   always_ff @(posedge clock) begin
      if (ce) begin
         pin_s1_reg <= {pin_b_in, pin_a_in};
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         for (int i = 0; i < 12; i++) begin
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
               pin_val_reg[i] <= pin_s3_reg[i];
            end
         end
      end
   end

   // registered read answer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_data_reg <= `CSRB_ZERO8;
      end else if (ce && rd_en) begin
         rd_data_reg <= rd_mux;
      end
   end

   // outputs straight from flip-flops
   assign rd_data            = rd_data_reg;
   assign flags_out          = flags_reg;
   assign timer_count_out    = timer_reg;
   assign pc_low_out         = pcl_reg;
   assign pin_a_latch        = lat_a_reg;
   assign pin_b_latch        = lat_b_reg;
   assign dir_a              = dir_a_reg;
   assign dir_b              = dir_b_reg;
   assign timer_prescale_cfg = prescale_reg;
   assign added_feature_cfg  = added_reg;

   // computed zero flag lands even when the flags are the target
   property p_flag_protect;
      @(posedge clock) disable iff (!rst_n)
      (ce && wr_flags && flag_upd[`CSRB_BIT_ZERO])
         |=> (flags_reg[`CSRB_BIT_ZERO] == $past(alu_zero));
   endproperty
   a_flag_protect: assert property (p_flag_protect)
      else $error("zero flag took written value");
   // watchdog and sleep flags unmoved by a plain write; wake flag taken
   property p_ro_flags;
      @(posedge clock) disable iff (!rst_n)
      (wr_flags && !sleep_op && !wdt_clear_op)
         |=> ($stable(flags_reg[4:3])
              && flags_reg[`CSRB_BIT_PCWAKE] == $past(wr_data[`CSRB_BIT_PCWAKE]));
   endproperty
   a_ro_flags: assert property (p_ro_flags)
      else $error("protected flag write misbehaved");
   // clearing the flags leaves top three zero and zero flag set
   property p_clear_flags;
      @(posedge clock) disable iff (!rst_n)
      (wr_flags && wr_data == `CSRB_ZERO8 && flag_upd == 3'h4 && alu_zero)
         |=> (flags_reg[7:5] == 3'b000 && flags_reg[`CSRB_BIT_ZERO] && $stable(flags_reg[1:0]));
   endproperty
   a_clear_flags: assert property (p_clear_flags)
      else $error("flag clear result wrong");
   // prescale config shows the loaded accumulator value one cycle after the load
   property p_prescale_load;
      @(posedge clock) disable iff (!rst_n)
      (ld_prescale ##1 (!ld_prescale && rst_n))
         |-> (prescale_reg == $past(acc_data[5:0], 1));
   endproperty
   a_prescale_load: assert property (p_prescale_load)
      else $error("prescale load lost");
   // any reset sets the prescale config to ones
   property p_prescale_reset;
      @(posedge clock) (!rst_n) |=> (prescale_reg == `CSRB_RST_CFG6);
   endproperty
   a_prescale_reset: assert property (p_prescale_reset)
      else $error("prescale not ones after reset");
   // power-on reset sets the added-feature config to ones
   property p_added_por;
      @(posedge clock) (!rst_n && reset_cause == CSRB_CAUSE_POR)
         |=> (added_reg == `CSRB_RST_CFG6);
   endproperty
   a_added_por: assert property (p_added_por)
      else $error("added config not ones after power-on");
   // upper port a bits always read as zero
   property p_port_a_zero;
      @(posedge clock) disable iff (!rst_n)
      (ce && rd_en && eff_addr == `CSRB_ADDR_PORT_A) |=> (rd_data[7:4] == 4'h0);
   endproperty
   a_port_a_zero: assert property (p_port_a_zero)
      else $error("port a upper bits not zero");
   // indirect read returns the memory cell at the pointer
   property p_indirect_read;
      @(posedge clock) disable iff (!rst_n)
      (ce && rd_en && is_indirect && gpr_hit) |=> (rd_data == $past(gpr_rdata));
   endproperty
   a_indirect_read: assert property (p_indirect_read)
      else $error("indirect read mismatch");
   // low program counter byte reads back as held
   property p_pcl_read;
      @(posedge clock) disable iff (!rst_n)
      (ce && rd_en && eff_addr == `CSRB_ADDR_PCL) |=> (rd_data == $past(pcl_reg));
   endproperty
   a_pcl_read: assert property (p_pcl_read)
      else $error("program counter byte read mismatch");
   // config registers other than port a direction untouched without their load strobes
   property p_cfg_hold;
      @(posedge clock) disable iff (!rst_n)
      (!ld_added && !ld_dir_b && !option_load) |=> ($stable(added_reg)
         && $stable(dir_b_reg) && $stable(prescale_reg));
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("config changed without load");
   // main scenarios
   c_flags_write: cover property (@(posedge clock) disable iff (!rst_n)
      wr_flags && flag_upd != 3'b000);
   c_indirect_wr: cover property (@(posedge clock) disable iff (!rst_n)
      wr_now && is_indirect && gpr_hit);
   c_added_load: cover property (@(posedge clock) disable iff (!rst_n) ld_added);
   c_sleep: cover property (@(posedge clock) disable iff (!rst_n) ce && sleep_op);
endmodule

// [tb/core_special_register_bank_test.sv]
`timescale 1ns/1ps
`include "csrb_defines.svh"

module core_special_register_bank_test
   import csrb_pkg::*;
;
   logic        clock = 0, rst_n = 0, ce = 1, rd_en = 0, wr_en = 0;
   csrb_cause_t reset_cause = CSRB_CAUSE_POR;
   logic [4:0]  file_addr = 5'h00;
   logic [7:0]  wr_data = 8'h00, acc_data = 8'h00, pc_low_in = 8'h00, pin_b_in = 8'h00;
   logic [2:0]  flag_upd = 3'h0, cfg_sel = 3'h0;
   logic        alu_zero = 0, sleep_op = 0, wdt_clear_op = 0, option_load = 0;
   logic        alu_carry = 0, alu_nibble = 0;
   logic        cfg_load = 0, timer_inc = 0, pc_low_upd = 0;
   logic [3:0]  pin_a_in = 4'h0;
   logic [7:0]  rd_data, flags_out, timer_count_out, pc_low_out, pin_b_latch, dir_b;
   logic [3:0]  pin_a_latch, dir_a;
   logic [5:0]  timer_prescale_cfg, added_feature_cfg;
   int          n_fail = 0, comparisons = 0, cycles = 0;

   csrb_special_regs csrb_special_regs_i (
      .clock(clock), .rst_n(rst_n), .ce(ce), .reset_cause(reset_cause),
      .file_addr(file_addr), .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data),
      .flag_upd(flag_upd), .alu_carry(alu_carry), .alu_nibble(alu_nibble), .alu_zero(alu_zero),
      .sleep_op(sleep_op), .wdt_clear_op(wdt_clear_op), .option_load(option_load),
      .cfg_load(cfg_load), .cfg_sel(cfg_sel), .acc_data(acc_data), .timer_inc(timer_inc),
      .pc_low_upd(pc_low_upd), .pc_low_in(pc_low_in), .pin_a_in(pin_a_in),
      .pin_b_in(pin_b_in), .rd_data(rd_data), .flags_out(flags_out),
      .timer_count_out(timer_count_out), .pc_low_out(pc_low_out),
      .pin_a_latch(pin_a_latch), .pin_b_latch(pin_b_latch), .dir_a(dir_a), .dir_b(dir_b),
      .timer_prescale_cfg(timer_prescale_cfg), .added_feature_cfg(added_feature_cfg)
   );

   // free-running 50 MHz clock
   initial begin
      forever #10 clock = ~clock;
   end

   // hang guard, well above the hundred or so cycles the tests need
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_fail++;
         wrap_up();
      end
   end

   // compare seen against expected, count both outcomes
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // synchronous reset with a given cause, held two edges
   task automatic rst(input csrb_cause_t c);
      @(posedge clock);
      rst_n <= 0;
      reset_cause <= c;
      repeat (2) @(posedge clock);
      rst_n <= 1;
      @(negedge clock);
   endtask

   // one instruction cycle: optional write plus one side pulse (k selects it)
   task automatic op(input logic we, input logic [4:0] a, input logic [7:0] d,
                     input logic [2:0] u, input logic z, input int k);
      @(posedge clock);
      wr_en <= we;
      file_addr <= a;
      wr_data <= d;
      flag_upd <= u;
      alu_zero <= z;
      timer_inc <= (k == 1);
      sleep_op <= (k == 2);
      wdt_clear_op <= (k == 3);
      option_load <= (k == 4);
      cfg_load <= (k == 5);
      pc_low_upd <= (k == 6);
      @(posedge clock);
      {wr_en, timer_inc, sleep_op, wdt_clear_op, option_load, cfg_load, pc_low_upd} <= 7'h00;
      flag_upd <= 3'h0;
      @(negedge clock);
   endtask

   // operand read, answer registered one cycle later
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge clock);
      file_addr <= a;
      rd_en <= 1;
      @(posedge clock);
      rd_en <= 0;
      @(negedge clock);
      check(rd_data, exp);
   endtask

   // power-on values of every reset register
   task automatic t_por();
      check(pc_low_out, `CSRB_RST_PCL);
      check({4'h0, dir_a}, 8'h0f);
      check(dir_b, 8'hff);
      check({2'b00, timer_prescale_cfg}, 8'h3f);
      check({2'b00, added_feature_cfg}, 8'h3f);
      check(flags_out, 8'h98);
      check(rd_data, 8'h00);
      $display("test por done");
   endtask

   // software keeps to bit set/clear/store style writes, plus one clear
   task automatic t_flags();
      op(1, `CSRB_ADDR_FLAGS, 8'h03, 3'h0, 0, 0);
      check(flags_out, 8'h1b);
      op(1, `CSRB_ADDR_FLAGS, 8'h00, 3'b100, 1, 0);
      check(flags_out, 8'h1f);
      @(posedge clock);
      alu_carry <= 1;
      alu_nibble <= 1;
      op(1, `CSRB_ADDR_FLAGS, 8'hff, 3'b111, 0, 0);
      check(flags_out, 8'hfb);
      op(1, `CSRB_ADDR_FLAGS, 8'h00, 3'b000, 0, 0);
      check(flags_out, 8'h18);
      op(1, `CSRB_ADDR_FLAGS, 8'h80, 3'b000, 0, 0);
      check(flags_out, 8'h98);
      rd(`CSRB_ADDR_FLAGS, 8'h98);
      $display("test flags done");
   endtask

   // configuration loads from the accumulator
   task automatic t_cfg();
      @(posedge clock);
      acc_data <= 8'hc5;
      op(0, 5'h00, 8'h00, 3'h0, 0, 4);
      check({2'b00, timer_prescale_cfg}, 8'h05);
      @(posedge clock);
      cfg_sel <= `CSRB_CFG_DIR_A;
      acc_data <= 8'h03;
      op(0, 5'h00, 8'h00, 3'h0, 0, 5);
      @(posedge clock);
      cfg_sel <= `CSRB_CFG_DIR_B;
      acc_data <= 8'ha5;
      op(0, 5'h00, 8'h00, 3'h0, 0, 5);
      @(posedge clock);
      cfg_sel <= `CSRB_CFG_ADDED;
      acc_data <= 8'h2a;
      op(0, 5'h00, 8'h00, 3'h0, 0, 5);
      @(posedge clock);
      cfg_sel <= 3'h4;
      acc_data <= 8'h00;
      op(0, 5'h00, 8'h00, 3'h0, 0, 5);
      check({4'h0, dir_a}, 8'h03);
      check(dir_b, 8'ha5);
      check({2'b00, added_feature_cfg}, 8'h2a);
      // frozen clock enable blocks the load
      @(posedge clock);
      ce <= 0;
      acc_data <= 8'h11;
      op(0, 5'h00, 8'h00, 3'h0, 0, 4);
      @(posedge clock);
      ce <= 1;
      rd(`CSRB_ADDR_FLAGS, 8'h98);
      check({2'b00, timer_prescale_cfg}, 8'h05);
      $display("test cfg done");
   endtask

   // pointer, indirect port and direct access to the same cell
   task automatic t_indirect();
      op(1, `CSRB_ADDR_POINTER, 8'h0a, 3'h0, 0, 0);
      rd(`CSRB_ADDR_POINTER, 8'hea);
      op(1, `CSRB_ADDR_INDIRECT, 8'h5a, 3'h0, 0, 0);
      rd(5'h0a, 8'h5a);
      op(1, 5'h0a, 8'h33, 3'h0, 0, 0);
      rd(`CSRB_ADDR_INDIRECT, 8'h33);
      op(1, `CSRB_ADDR_POINTER, 8'h00, 3'h0, 0, 0);
      rd(`CSRB_ADDR_INDIRECT, 8'h00);
      $display("test indirect done");
   endtask

   // pins, timer and low program counter byte
   task automatic t_misc();
      @(posedge clock);
      pin_a_in <= 4'ha;
      pin_b_in <= 8'h3c;
      repeat (6) @(posedge clock);
      rd(`CSRB_ADDR_PORT_A, 8'h0a);
      rd(`CSRB_ADDR_PORT_B, 8'h3c);
      op(1, `CSRB_ADDR_PORT_A, 8'hf7, 3'h0, 0, 0);
      check({4'h0, pin_a_latch}, 8'h07);
      op(1, `CSRB_ADDR_PORT_B, 8'hc3, 3'h0, 0, 0);
      check(pin_b_latch, 8'hc3);
      rd(`CSRB_ADDR_PORT_B, 8'h3c);
      op(1, `CSRB_ADDR_TIMER, 8'h10, 3'h0, 0, 0);
      op(0, 5'h00, 8'h00, 3'h0, 0, 1);
      rd(`CSRB_ADDR_TIMER, 8'h11);
      op(1, `CSRB_ADDR_TIMER, 8'h40, 3'h0, 0, 1);
      check(timer_count_out, 8'h40);
      @(posedge clock);
      pc_low_in <= 8'h34;
      op(0, 5'h00, 8'h00, 3'h0, 0, 6);
      rd(`CSRB_ADDR_PCL, 8'h34);
      op(1, `CSRB_ADDR_PCL, 8'h56, 3'h0, 0, 0);
      check(pc_low_out, 8'h56);
      $display("test misc done");
   endtask

   // every reset cause except power-on, and the sleep and watchdog instructions
   task automatic t_resets();
      op(0, 5'h00, 8'h00, 3'h0, 0, 2);
      check(flags_out, 8'h90);
      rst(CSRB_CAUSE_WDT);
      check(flags_out, 8'h80);
      op(0, 5'h00, 8'h00, 3'h0, 0, 3);
      check(flags_out, 8'h98);
      rst(CSRB_CAUSE_WAKE);
      check(flags_out, 8'h18);
      rst(CSRB_CAUSE_EXT);
      check(flags_out, 8'h98);
      check({2'b00, timer_prescale_cfg}, 8'h3f);
      check({2'b00, added_feature_cfg}, 8'h2a);
      check(pc_low_out, 8'hff);
      op(1, `CSRB_ADDR_FLAGS, 8'h60, 3'h0, 0, 0);
      rst(CSRB_CAUSE_BOR);
      check(flags_out, 8'h18);
      check({2'b00, timer_prescale_cfg}, 8'h3f);
      $display("test resets done");
   endtask

   // counts and verdict, then stop
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      rst(CSRB_CAUSE_POR);
      t_por();
      t_flags();
      t_cfg();
      t_indirect();
      t_misc();
      t_resets();
      wrap_up();
   end
endmodule
